// ==== dv/dbsp_cmd_source.sv ====
// Command stream source model that feeds state packet dwords to the decoder
`timescale 1ns/1ps
module dbsp_cmd_source (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        cmd_ready,
  input  wire logic        slow,
  output logic             cmd_valid,
  output logic [31:0]      cmd_data
);
  logic [31:0] q[$];
  logic        hold;

  task automatic push(input logic [31:0] d);
    q.push_back(d);
  endtask

  // Only dwords are carried: memory placement, render target types and cache
  // flushes lie with software beyond this model
  // Idle data is inverted each cycle so a stale dword never looks settled
  always @(posedge clk or posedge reset) begin
    if (reset) begin
      cmd_valid <= 1'b0;
      cmd_data  <= 32'h0;
      hold      <= 1'b0;
    end else if (!cmd_valid || cmd_ready) begin
      if (q.size() != 0 && !hold) begin
        cmd_valid <= 1'b1;
        cmd_data  <= q.pop_front();
        hold      <= slow;
      end else begin
        cmd_valid <= 1'b0;
        cmd_data  <= ~cmd_data;
        hold      <= 1'b0;
      end
    end
  end
endmodule // dbsp_cmd_source

// ==== dv/testbench.sv ====
// Self-checking bench for the depth surface state packet decoder
`timescale 1ns/1ps
module testbench;
  import dbsp_pkg::*;
  localparam logic [31:0] HDR = 32'h7905_0003;
  localparam logic [31:0] ORG = 32'h0020_0010;
  localparam logic [2:0]  TYPES [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  localparam logic [31:0] BAD [4] = '{32'h5905_0003, 32'h7105_0003, 32'h7A05_0003, 32'h7906_0003};
  logic           clk, reset, ce, slow, cmd_valid, cmd_ready;
  logic [31:0]    cmd_data, d;
  logic           z_test_en, stencil_test_en, z_write_en;
  logic           q_z_test_en, q_stencil_test_en, q_z_write_en;
  logic           px_valid, pxo_valid, eff_y_major, no_depth_writeback;
  logic [15:0]    px_x, px_y, depth_x, depth_y, color_x, color_y;
  dbsp_state_type depth_state;
  logic [31:0]    s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0]     s_axi_wstrb;
  logic [1:0]     s_axi_bresp, s_axi_rresp;
  logic           s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic           s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int             n_fail, n_compared;

  dbsp_decoder dbsp_decoder_inst (
    .clk, .reset, .ce, .cmd_valid, .cmd_data, .cmd_ready, .z_test_en, .stencil_test_en, .z_write_en,
    .q_z_test_en, .q_stencil_test_en, .q_z_write_en, .px_valid, .px_x, .px_y, .pxo_valid,
    .depth_x, .depth_y, .color_x, .color_y, .depth_state, .eff_y_major, .no_depth_writeback,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  dbsp_cmd_source dbsp_cmd_source_inst (.clk, .reset, .cmd_ready, .slow, .cmd_valid, .cmd_data);

  always #5 clk = ~clk;

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tmo(input int i, input int lim);
    if (i >= lim) begin
      n_fail++;
      $display("ERROR at %0t ns: wait ran out, got %h expected %h", $time, i, lim);
      end_sim;
    end
  endtask

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] er);
    int  i;
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (i = 0; i < 50 && !(ta && tw); i++) begin
      @(posedge clk);
      if (!ta && s_axi_awready) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    tmo(i, 50);
    // Response may only be taken once both halves are in
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_bvalid) break;
    end
    tmo(i, 50);
    s_axi_bready <= 1'b0;
    chk(32'(s_axi_bresp), 32'(er));
  endtask

  task automatic axi_rd(input logic [31:0] a, input logic [1:0] er, output logic [31:0] v);
    int i;
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_arready) break;
    end
    tmo(i, 50);
    s_axi_arvalid <= 1'b0;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_rvalid) break;
    end
    tmo(i, 50);
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk(32'(s_axi_rresp), 32'(er));
  endtask

  // Fillers repeat a valid header so a miscounted skip shows up as a wrong capture
  task automatic push_pkt(input logic [31:0] h, input logic [31:0] d1);
    int i;
    @(negedge clk);
    dbsp_cmd_source_inst.push(h);
    dbsp_cmd_source_inst.push(d1);
    for (i = 0; i < int'(h[7:0]); i++) dbsp_cmd_source_inst.push(HDR);
  endtask

  task automatic idle;
    int i;
    for (i = 0; i < 200; i++) begin
      @(posedge clk);
      if (!cmd_valid && dbsp_cmd_source_inst.q.size() == 0) break;
    end
    tmo(i, 200);
    repeat (2) @(posedge clk);
    #1;
  endtask

  task automatic cfg(input logic [31:0] h, input logic [2:0] t, input logic ti, wk, od, input logic [1:0] m);
    push_pkt(h, {t, 1'b0, ti, wk, od, m, 23'h0});
    idle;
    chk(32'(depth_state), {24'h0, t, ti, wk, od, m});
    chk(32'(eff_y_major), 32'(ti & wk));
    chk(32'(no_depth_writeback), 32'(m == 2'h3));
    chk(32'({q_z_test_en, q_stencil_test_en, q_z_write_en}), {29'h0, {3{t != empty_surface}}});
  endtask

  task automatic pix(input logic [15:0] x, input logic [15:0] y, input logic od);
    @(posedge clk);
    px_valid <= 1'b1;
    px_x     <= x;
    px_y     <= y;
    @(posedge clk);
    px_valid <= 1'b0;
    #1;
    chk(32'(pxo_valid), 32'h1);
    chk({color_y, color_x}, {y + ORG[31:16], x + ORG[15:0]});
    chk({depth_y, depth_x}, od ? {y, x} : {y + ORG[31:16], x + ORG[15:0]});
  endtask

  initial begin
    {clk, ce, reset, slow, px_valid, px_x, px_y} = {3'b011, 34'h0};
    {z_test_en, stencil_test_en, z_write_en} = 3'h7;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = {96'h0, 4'hF};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk(32'(depth_state), 32'(STATE_RESET));
    chk(32'({q_z_test_en, q_stencil_test_en, q_z_write_en}), 32'h0);
    axi_rd(CTRL_ADDR, RESP_OKAY, d);
    chk(d, CTRL_RESET);
    axi_rd(STATE_ADDR, RESP_OKAY, d);
    chk(d, 32'hE000_0001);
    slow = 1'b1;
    foreach (TYPES[k]) cfg(HDR, TYPES[k], 1'b1, 1'b1, 1'b0, 2'h0);
    slow = 1'b0;
    cfg(HDR, two_dim_surface, 1'b0, 1'b1, 1'b0, 2'h0);
    cfg(HDR, two_dim_surface, 1'b1, 1'b0, 1'b0, 2'h0);
    cfg(HDR, volume_surface, 1'b1, 1'b1, 1'b0, cache_resident_depth_mode);
    cfg(HDR, volume_surface, 1'b1, 1'b1, 1'b0, block_tiled_render_mode);
    axi_rd(STATE_ADDR, RESP_OKAY, d);
    chk(32'(d[10]), 32'h1);
    axi_wr(ERR_ADDR, 32'h1, RESP_OKAY);
    axi_rd(ERR_ADDR, RESP_OKAY, d);
    chk(d, 32'h0);
    cfg(HDR, cube_surface, 1'b1, 1'b1, 1'b0, 2'h0);
    @(posedge clk);
    z_test_en <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(32'({q_z_test_en, q_stencil_test_en, q_z_write_en}), 32'h3);
    @(posedge clk);
    z_test_en <= 1'b1;
    axi_wr(ORIGIN_ADDR, ORG, RESP_OKAY);
    axi_rd(ORIGIN_ADDR, RESP_OKAY, d);
    chk(d, ORG);
    cfg(HDR, two_dim_surface, 1'b1, 1'b1, 1'b1, 2'h0);
    pix(16'h0005, 16'h0006, 1'b1);
    pix(16'hFFF8, 16'hFFF0, 1'b1);
    cfg(HDR, two_dim_surface, 1'b1, 1'b1, 1'b0, 2'h0);
    pix(16'h0005, 16'h0006, 1'b0);
    foreach (BAD[k]) begin
      push_pkt(BAD[k], 32'h0);
      idle;
      chk(32'(depth_state), {24'h0, two_dim_surface, 5'b11000});
    end
    axi_rd(STATE_ADDR, RESP_OKAY, d);
    chk(32'(d[8]), 32'h1);
    // Short packet straight into a normal one: both must frame correctly
    push_pkt(32'h7905_0001, {cube_surface, 29'h0});
    cfg(HDR, one_dim_surface, 1'b0, 1'b0, 1'b0, 2'h0);
    axi_rd(STATE_ADDR, RESP_OKAY, d);
    chk(32'(d[9]), 32'h1);
    axi_wr(CTRL_ADDR, 32'h0, RESP_OKAY);
    push_pkt(HDR, {cube_surface, 29'h0});
    idle;
    chk(32'(depth_state), 32'h0);
    axi_wr(CTRL_ADDR, CTRL_RESET, RESP_OKAY);
    axi_wr(32'h0000_0010, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_rd(32'h0000_0010, RESP_SLVERR, d);
    chk(d, 32'h0);
    end_sim;
  end
endmodule // testbench

// ==== hdl/dbsp_decoder.sv ====
// Depth surface state packet decoder with AXI4-Lite status and control
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module dbsp_decoder
  import dbsp_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        ce,
  input  wire logic        cmd_valid,
  input  wire logic [31:0] cmd_data,
  output logic             cmd_ready,
  input  wire logic        z_test_en,
  input  wire logic        stencil_test_en,
  input  wire logic        z_write_en,
  output logic             q_z_test_en,
  output logic             q_stencil_test_en,
  output logic             q_z_write_en,
  input  wire logic        px_valid,
  input  wire logic [15:0] px_x,
  input  wire logic [15:0] px_y,
  output logic             pxo_valid,
  output logic [15:0]      depth_x,
  output logic [15:0]      depth_y,
  output logic [15:0]      color_x,
  output logic [15:0]      color_y,
  output dbsp_state_type   depth_state,
  output logic             eff_y_major,
  output logic             no_depth_writeback,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = new_v[8*i +: 8];
      end
    end
    return res;
  endfunction

  // Registers
  logic [31:0]    ctrl;
  logic [31:0]    origin;
  logic [15:0]    err_count;
  logic           hdr_err;
  logic           len_err;
  logic           mode_err;
  dbsp_fsm_type   fsm;
  logic [7:0]     skip_left;

  // Packet decode
  wire take       = ce & cmd_valid & cmd_ready;
  wire dec_on     = ctrl[0];
  wire hdr_type   = cmd_data[31:29] == graphics_pipe_command_type;  // see RQ2
  wire hdr_sub    = cmd_data[28:27] == three_d_command_subtype;     // see RQ2
  wire hdr_op     = cmd_data[26:24] == unpipelined_state_group;     // see RQ3
  wire hdr_subop  = cmd_data[23:16] == depth_surface_state_packet;  // see RQ4
  wire hdr_match  = hdr_type & hdr_sub & hdr_op & hdr_subop & dec_on;
  wire [7:0] len  = cmd_data[7:0];
  wire head_take  = take & (fsm == ST_HEAD);
  wire body_take  = take & (fsm == ST_BODY);
  wire skip_take  = take & (fsm == ST_SKIP);
  wire [1:0] d1_mode = cmd_data[MODE_HI -: 2];

  // A header that is not ours still has its length honoured, so the
  // decoder stays in step with the command stream.
  dbsp_fsm_type next_fsm;
  logic [7:0]   next_skip;
  always_comb begin
    next_fsm  = fsm;
    next_skip = skip_left;
    case (fsm)
      ST_HEAD: begin
        if (head_take) begin
          next_skip = len;                                // see RQ5
          next_fsm  = hdr_match ? ST_BODY : ST_SKIP;
        end
      end
      ST_BODY: begin
        if (body_take) begin
          // Dword 1 counts against the length, so the skip resumes one lower
          next_skip = skip_left - 8'h01;                  // see RQ5
          next_fsm = (skip_left == 8'h00) ? ST_HEAD : ST_SKIP;
        end
      end
      ST_SKIP: begin
        if (skip_take) begin
          next_skip = skip_left - 8'h01;
          if (skip_left == 8'h00) begin
            next_fsm = ST_HEAD;
          end
        end
      end
      default: begin
        next_fsm = ST_HEAD;
      end
    endcase
  end

  // Field capture: applied straight from dword 1, outside any pipeline
  dbsp_state_type next_state;
  always_comb begin
    next_state = depth_state;                            // see RQ21
    if (body_take) begin                                 // see RQ1
      next_state.surf_type  = cmd_data[TYPE_HI -: 3];    // see RQ6
      next_state.tiled      = cmd_data[TILED_BIT];       // see RQ8
      next_state.walk       = cmd_data[WALK_BIT];
      next_state.offset_dis = cmd_data[OFFDIS_BIT];
      next_state.mode       = d1_mode;                   // see RQ15
    end
  end

  // Derived controls; reserved surface codes behave as non-empty
  wire is_empty  = depth_state.surf_type == empty_surface;
  wire next_empty = next_state.surf_type == empty_surface;
  wire next_ymaj = next_state.tiled &                    // see RQ11
                   (next_state.walk == y_major_tiling);  // see RQ10
  wire next_nowb = next_state.mode == cache_resident_depth_mode; // see RQ18
  wire [15:0] org_x = origin[15:0];
  wire [15:0] org_y = origin[31:16];
  wire [15:0] z_org_x = depth_state.offset_dis ? 16'h0000 : org_x; // see RQ13
  wire [15:0] z_org_y = depth_state.offset_dis ? 16'h0000 : org_y; // see RQ13

  wire bad_len   = head_take & hdr_match & (len != NOMINAL_LEN);   // see RQ5
  wire bad_hdr   = head_take & ~hdr_match & dec_on;
  wire bad_mode  = body_take & (d1_mode != normal_render_mode);    // see RQ15

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      fsm         <= ST_HEAD;
      skip_left   <= 8'h00;
      cmd_ready   <= 1'b0;
      depth_state <= STATE_RESET;
      eff_y_major <= 1'b0;
      no_depth_writeback <= 1'b0;
    end else if (ce) begin
      fsm         <= next_fsm;
      skip_left   <= next_skip;
      cmd_ready   <= 1'b1;
      depth_state <= next_state;
      eff_y_major <= next_ymaj;
      no_depth_writeback <= next_nowb;
    end
  end

  // Test enables qualified by the surface being loaded (next_state), so they switch with depth_state
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      q_z_test_en       <= 1'b0;
      q_stencil_test_en <= 1'b0;
      q_z_write_en      <= 1'b0;
    end else if (ce) begin
      q_z_test_en       <= z_test_en & ~next_empty;        // see RQ20
      q_stencil_test_en <= stencil_test_en & ~next_empty;  // see RQ20
      q_z_write_en      <= z_write_en & ~next_empty;       // see RQ20
    end
  end

  // Coordinate path: colour always gets the origin, depth only when allowed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pxo_valid <= 1'b0;
      depth_x   <= 16'h0000;
      depth_y   <= 16'h0000;
      color_x   <= 16'h0000;
      color_y   <= 16'h0000;
    end else if (ce) begin
      pxo_valid <= px_valid;
      depth_x   <= px_x + z_org_x;
      depth_y   <= px_y + z_org_y;
      color_x   <= px_x + org_x;
      color_y   <= px_y + org_y;
    end
  end

  // Sticky errors: a new error wins over a clear in the same cycle
  logic       clr_err;
  wire [15:0] err_inc = (bad_len | bad_hdr | bad_mode) ? 16'h0001 : 16'h0000;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hdr_err   <= 1'b0;
      len_err   <= 1'b0;
      mode_err  <= 1'b0;
      err_count <= 16'h0000;
    end else if (ce) begin
      hdr_err   <= bad_hdr | (hdr_err & ~clr_err);
      len_err   <= bad_len | (len_err & ~clr_err);
      mode_err  <= bad_mode | (mode_err & ~clr_err);
      err_count <= (clr_err ? 16'h0000 : err_count) + err_inc;
    end
  end

  // AXI4-Lite write: address and data taken in either order
  logic        aw_held;
  logic        w_held;
  logic [31:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire aw_take = ce & s_axi_awvalid & s_axi_awready;
  wire w_take  = ce & s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_held & w_held & ~s_axi_bvalid;
  wire wr_ctrl = wr_go & (aw_addr == CTRL_ADDR);
  wire wr_org  = wr_go & (aw_addr == ORIGIN_ADDR);
  wire wr_err  = wr_go & (aw_addr == ERR_ADDR);
  wire wr_ok   = wr_ctrl | wr_org | wr_err;
  assign clr_err = wr_err & w_data[0];

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 32'h0000_0000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      ctrl          <= CTRL_RESET;
      origin        <= 32'h0000_0000;
    end else if (ce) begin
      s_axi_awready <= ~aw_held & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held & ~w_take & ~s_axi_bvalid;
      if (aw_take) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (wr_ctrl) begin
        ctrl <= merge(ctrl, w_data, w_strb) & 32'h0000_0001;
      end
      if (wr_org) begin
        origin <= merge(origin, w_data, w_strb);
      end
    end
  end

  // AXI4-Lite read
  wire rd_take = ce & s_axi_arvalid & s_axi_arready;
  wire [31:0] state_word = {depth_state.surf_type, depth_state.tiled,
                            depth_state.walk, depth_state.offset_dis,
                            depth_state.mode, 13'h0000, mode_err, len_err,
                            hdr_err, eff_y_major, no_depth_writeback,
                            3'h0, fsm, is_empty};
  logic [31:0] rd_word;
  logic        rd_ok;
  always_comb begin
    rd_ok   = 1'b1;
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == CTRL_ADDR) begin
      rd_word = ctrl;
    end else if (s_axi_araddr == STATE_ADDR) begin
      rd_word = state_word;
    end else if (s_axi_araddr == ORIGIN_ADDR) begin
      rd_word = origin;
    end else if (s_axi_araddr == ERR_ADDR) begin
      rd_word = {16'h0000, err_count};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_take;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence good_head_s;
    head_take && hdr_match;
  endsequence

  sequence body_s;
    body_take;
  endsequence

  head_to_body_a: assert property (good_head_s |=> fsm == ST_BODY) // see RQ4
    else $error("Matching header did not lead to body capture");
  foreign_skip_a: assert property (head_take && !hdr_subop |=> fsm != ST_BODY) // see RQ4
    else $error("Foreign header started a capture");
  capture_type_a: assert property (body_s |=>
                                   depth_state.surf_type == $past(cmd_data[31:29])) // see RQ6
    else $error("Surface type not captured from dword 1");
  hold_fields_a: assert property (!body_take |=> $stable(depth_state)) // see RQ21
    else $error("Depth state changed without a packet");
  empty_gate_a: assert property (ce && z_test_en && next_empty |=> !q_z_test_en) // see RQ20
    else $error("Depth test enabled on empty surface");
  linear_walk_a: assert property (ce && body_take && !cmd_data[TILED_BIT] |=> !eff_y_major) // see RQ11
    else $error("Tile walk used on linear surface");
  depth_offset_a: assert property (ce && px_valid && depth_state.offset_dis && !body_take
                                   |=> depth_x == $past(px_x)) // see RQ13
    else $error("Origin added to depth with offset disabled");
  nowb_mode_a: assert property (ce && body_take && d1_mode == cache_resident_depth_mode
                                |=> no_depth_writeback) // see RQ18
    else $error("Depth writeback not blocked in cache resident mode");
  len_err_a: assert property (good_head_s ##0 (len != NOMINAL_LEN) |=> len_err) // see RQ5
    else $error("Bad length not flagged");
  skip_len_a: assert property (good_head_s ##0 (len == NOMINAL_LEN) |=> skip_left == 8'h03) // see RQ5
    else $error("Length not loaded for skipping");

endmodule // dbsp_decoder

// ==== hdl/dbsp_pkg.sv ====
// Package for the depth surface state packet decoder: layouts, codes, register map
// Operation
// RQ1: Depth surface state is taken as unpipelined state, applied at once.
// RQ2: Header bits 31:29 and 28:27 must both hold 3h.
// RQ3: Header opcode bits 26:24 must be 1h, the unpipelined group.
// RQ4: Header sub-opcode bits 23:16 must be 05h for this packet.
// RQ5: Header length bits 7:0 hold total dwords minus 2, nominally 3h.
// RQ6: Surface type 0-3 are 1D, 2D, volume, cube; 7 empty; 4-6 reserved.
// RQ7: Software matches depth and colour surface types unless either is empty.
// RQ8: A dword 1 bit says whether the surface is tiled or linear.
// RQ9: Software keeps tiled surfaces in uncached main memory only.
// RQ10: Tile walk bit 26 value 1 means Y-major, 0 is reserved.
// RQ11: Tile walk is ignored while the surface is linear.
// RQ12: Software always picks Y-major for a tiled depth surface.
// RQ13: Bit 25 set drops the origin offset from depth, not colour, coordinates.
// RQ14: Software sets bit 25 for field-mode surfaces with line skipping.
// RQ15: Tiled rendering mode bits 24:23 must be 0h; other codes reserved.
// RQ16: Software flushes the render cache before changing the tiled mode.
// RQ17: First tiled mode keeps rendering inside one aligned 64x32 block.
// RQ18: Second tiled mode never writes depth back to memory.
// RQ19: Either tiled mode needs a Y-major depth surface.
// RQ20: Depth test, stencil test, depth write are off for an empty surface.
// RQ21: Captured fields hold until the next depth surface state packet.
// RQ22: Producer drives reserved header and dword 1 bits as zero.
package dbsp_pkg;
  localparam logic [2:0] graphics_pipe_command_type = 3'h3;
  localparam logic [1:0] three_d_command_subtype    = 2'h3;
  localparam logic [2:0] unpipelined_state_group    = 3'h1;
  localparam logic [7:0] depth_surface_state_packet = 8'h05;
  localparam logic [7:0] NOMINAL_LEN                = 8'h03;

  localparam logic [2:0] one_dim_surface = 3'h0;
  localparam logic [2:0] two_dim_surface = 3'h1;
  localparam logic [2:0] volume_surface  = 3'h2;
  localparam logic [2:0] cube_surface    = 3'h3;
  localparam logic [2:0] empty_surface   = 3'h7;

  localparam logic       y_major_tiling            = 1'h1;
  localparam logic [1:0] normal_render_mode        = 2'h0;
  localparam logic [1:0] block_tiled_render_mode   = 2'h1;
  localparam logic [1:0] cache_resident_depth_mode = 2'h3;

  localparam int TYPE_HI = 31;
  localparam int TILED_BIT = 27;
  localparam int WALK_BIT = 26;
  localparam int OFFDIS_BIT = 25;
  localparam int MODE_HI = 24;

  localparam logic [31:0] CTRL_ADDR   = 32'h0000_0000;
  localparam logic [31:0] STATE_ADDR  = 32'h0000_0004;
  localparam logic [31:0] ORIGIN_ADDR = 32'h0000_0008;
  localparam logic [31:0] ERR_ADDR    = 32'h0000_000C;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0001;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [2:0] surf_type;
    logic       tiled;
    logic       walk;
    logic       offset_dis;
    logic [1:0] mode;
  } dbsp_state_type;

  localparam dbsp_state_type STATE_RESET = '{surf_type: empty_surface, default: '0};

  typedef enum logic [1:0] {
    ST_HEAD = 2'b00,
    ST_BODY = 2'b01,
    ST_SKIP = 2'b10
  } dbsp_fsm_type;
endpackage
